// File: pkg/nsd_cfg.svh
`ifndef NSD_CFG_SVH
`define NSD_CFG_SVH
// opcode fields of the 14-bit instruction word
`define NSD_SWAP_OP 6'h0E
`define NSD_DIRL_OP 11'h00C
`define NSD_XORL_OP 6'h3A
`define NSD_DIRL_MIN 3'h5
`define NSD_DIRL_MAX 3'h7
// direction registers at file addresses 0x85..0x87, bank bit as msb
`define NSD_DIR_BASE 7'h05
`define NSD_DIR_RST 8'hFF
`define NSD_W_RST 8'h00
`define NSD_Z_RST 1'h0
`define NSD_FA_RST 7'h00
`define NSD_FD_RST 8'h00
`endif

// File: pkg/nsd_pkg.sv
package nsd_pkg;
    typedef enum {
        NSD_IDLE,
        NSD_EXEC
    } nsd_state_e;
    typedef struct packed {
        logic [7:0] w;
        logic [2:0][7:0] dir;
        logic z;
        logic f_we;
        logic [6:0] f_addr;
        logic [7:0] f_data;
        logic done;
    } nsd_st_s;
endpackage

// File: verilog/nsd_decode.sv
`timescale 1ns/10ps
`include "nsd_cfg.svh"
// --------------------------------------------------------------
// Summary of operation
// - swap opcode exchanges nibbles, flags untouched
// - dest bit selects accumulator or file register
// - direction load copies accumulator to port 5-7
// - direction registers also reachable as file registers
// - literal xor into accumulator, zero flag only
// --------------------------------------------------------------
module nsd_decode (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0] f_rdata,
    input wire logic dir_sel,
    input wire logic dir_we,
    input wire logic [1:0] dir_idx,
    input wire logic [7:0] dir_wdata,
    output logic [7:0] dir_rdata,
    output logic [6:0] f_addr,
    output logic [7:0] f_wdata,
    output logic f_we,
    output logic [7:0] w_out,
    output logic z_flag,
    output logic [23:0] dir_out,
    output logic done
);
    import nsd_pkg::*;

    nsd_st_s st_q, st_d;
    logic is_swap, is_dirl, is_xorl, is_hit, file_wr;
    logic [7:0] swapped, xored;
    logic [2:0] dsel;
    logic [2:0] dir_ld, dir_fw;
    logic [7:0] dir_nxt [3];

    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    assign is_swap = instr_valid && instr[13:8] == `NSD_SWAP_OP;
    assign dsel = instr[2:0];
    assign is_dirl = instr_valid && instr[13:3] == `NSD_DIRL_OP
        && dsel >= `NSD_DIRL_MIN && dsel <= `NSD_DIRL_MAX;
    assign is_xorl = instr_valid && instr[13:8] == `NSD_XORL_OP;
    assign swapped = {f_rdata[3:0], f_rdata[7:4]};
    assign xored = st_q.w ^ instr[7:0];
    // write-back lands a cycle late; file side keeps its own address copy
    assign f_addr = instr[6:0];
    assign is_hit = is_swap || is_dirl || is_xorl;
    // plain file access path; opcode load wins if both land
    assign file_wr = !is_hit && dir_sel && dir_we && dir_idx != 2'h3;

    // --------------------------------------------------------------
    // direction registers, one slice per port
    // --------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_dir
        assign dir_ld[g] = is_dirl && dsel == `NSD_DIRL_MIN + 3'(g);
        assign dir_fw[g] = file_wr && dir_idx == 2'(g);
        // both never meet: file_wr is blocked by any recognised opcode
        assign dir_nxt[g] = dir_ld[g] ? st_q.w
            : (dir_fw[g] ? dir_wdata : st_q.dir[g]);
    end

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.f_we = 1'b0;
        st_d.done = 1'b0;
        if (is_swap) begin
            st_d.done = 1'b1;
            if (instr[7]) begin
                st_d.f_we = 1'b1;
                st_d.f_addr = instr[6:0];
                st_d.f_data = swapped;
            end else begin
                st_d.w = swapped;
            end
        end else if (is_dirl) begin
            st_d.done = 1'b1;
        end else if (is_xorl) begin
            st_d.w = xored;
            st_d.z = (xored == 8'h00);
            st_d.done = 1'b1;
        end
        st_d.dir = {dir_nxt[2], dir_nxt[1], dir_nxt[0]};
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    // reset wins over ce so a frozen core can still be cleared
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '{
                w: `NSD_W_RST,
                dir: {3{`NSD_DIR_RST}},
                z: `NSD_Z_RST,
                f_we: 1'b0,
                f_addr: `NSD_FA_RST,
                f_data: `NSD_FD_RST,
                done: 1'b0
            };
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign dir_rdata = (dir_idx == 2'h3) ? 8'h00 : st_q.dir[dir_idx];
    assign f_wdata = st_q.f_data;
    assign f_we = st_q.f_we;
    assign w_out = st_q.w;
    assign z_flag = st_q.z;
    assign dir_out = st_q.dir;
    assign done = st_q.done;

    // --------------------------------------------------------------
    // swap checks
    // --------------------------------------------------------------
    a_swap_to_w: assert property (@(posedge clk) disable iff (rst)
        ce && is_swap && !instr[7] |=> w_out == $past(swapped)
        && z_flag == $past(z_flag))
        else $error("swap to w wrong");

    a_swap_to_f: assert property (@(posedge clk) disable iff (rst)
        ce && is_swap && instr[7] |=> f_we && f_wdata == $past(swapped)
        && w_out == $past(w_out))
        else $error("swap to f wrong");

    a_swap_addr: assert property (@(posedge clk) disable iff (rst)
        ce && is_swap && instr[7] |=> st_q.f_addr == $past(instr[6:0]))
        else $error("swap write-back address wrong");

    // --------------------------------------------------------------
    // direction register checks
    // --------------------------------------------------------------
    a_dir_load: assert property (@(posedge clk) disable iff (rst)
        ce && is_dirl && dsel == 3'h6 |=> dir_out[15:8] == $past(w_out)
        && z_flag == $past(z_flag))
        else $error("direction load wrong");

    a_dirl_first: assert property (@(posedge clk) disable iff (rst)
        ce && is_dirl && dsel == 3'h5 |=> dir_out[7:0] == $past(w_out))
        else $error("direction load to first port wrong");

    a_dirl_last: assert property (@(posedge clk) disable iff (rst)
        ce && is_dirl && dsel == 3'h7 |=> dir_out[23:16] == $past(w_out))
        else $error("direction load to last port wrong");

    a_dirl_refuse: assert property (@(posedge clk) disable iff (rst)
        ce && instr_valid && instr[13:3] == `NSD_DIRL_OP
        && dsel < `NSD_DIRL_MIN |=> !done && $stable(w_out))
        else $error("direction load with low operand executed");

    a_dirl_w_keep: assert property (@(posedge clk) disable iff (rst)
        ce && is_dirl |=> $stable(w_out) && $stable(z_flag) && !f_we)
        else $error("direction load touched accumulator or flags");

    a_dir_file: assert property (@(posedge clk) disable iff (rst)
        ce && !instr_valid && dir_sel && dir_we && dir_idx == 2'h0
        |=> dir_out[7:0] == $past(dir_wdata))
        else $error("direction file write wrong");

    a_dir_quiet: assert property (@(posedge clk) disable iff (rst)
        ce && !instr_valid && !(dir_sel && dir_we) |=> $stable(dir_out))
        else $error("direction register moved without a write");

    a_dir_unmapped: assert property (@(posedge clk) disable iff (rst)
        ce && !instr_valid && dir_sel && dir_we && dir_idx == 2'h3
        |=> $stable(dir_out))
        else $error("unmapped direction write landed");

    a_collide_drop: assert property (@(posedge clk) disable iff (rst)
        ce && is_dirl && dsel != 3'h6 && dir_sel && dir_we && dir_idx == 2'h1
        |=> $stable(dir_out[15:8]))
        else $error("file write beside direction load landed");

    // --------------------------------------------------------------
    // literal and timing checks
    // --------------------------------------------------------------
    a_xor_zero: assert property (@(posedge clk) disable iff (rst)
        ce && is_xorl |=> w_out == $past(xored)
        && z_flag == ($past(xored) == 8'h00))
        else $error("xor literal wrong");

    a_xor_side: assert property (@(posedge clk) disable iff (rst)
        ce && is_xorl |=> $stable(dir_out) && !f_we)
        else $error("literal xor touched more than accumulator and zero");

    a_one_cycle: assert property (@(posedge clk) disable iff (rst)
        ce && (is_swap || is_dirl || is_xorl) |=> done)
        else $error("instruction not done in one cycle");

    a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
        ce && !instr_valid |=> !done && !f_we)
        else $error("spurious completion");

    a_unknown_quiet: assert property (@(posedge clk) disable iff (rst)
        ce && instr_valid && !is_hit
        |=> !done && !f_we && $stable(w_out) && $stable(z_flag))
        else $error("unknown encoding had an effect");

    // expectation built from inputs, not from the xor net
    a_back_to_back: assert property (@(posedge clk) disable iff (rst)
        ce && is_xorl ##1 ce && is_dirl && dsel == 3'h7
        |=> dir_out[23:16] == ($past(w_out, 2) ^ $past(instr[7:0], 2)))
        else $error("accumulator result not ready for next instruction");

    // pulses hold as well; the file side must gate its write with ce
    a_freeze: assert property (@(posedge clk) disable iff (rst)
        !ce |=> $stable(w_out) && $stable(dir_out))
        else $error("state moved while frozen");

    // --------------------------------------------------------------
    // coverage
    // --------------------------------------------------------------
    c_swap: cover property (@(posedge clk) ce && is_swap);
    c_swap_f: cover property (@(posedge clk) ce && is_swap && instr[7]);
    c_dirl: cover property (@(posedge clk) ce && is_dirl);
    c_xor_z: cover property (@(posedge clk) ce && is_xorl && xored == 8'h00);
    c_dir_file: cover property (@(posedge clk) ce && file_wr);
endmodule

// File: verification/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
 $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic clk = 0, rst = 1, ce = 0, instr_valid = 0, dir_sel = 0, dir_we = 0;
    logic [13:0] instr = 0;
    logic [7:0] f_rdata = 0, dir_wdata = 0, dir_rdata, f_wdata, w_out;
    logic [1:0] dir_idx = 0;
    logic [6:0] f_addr;
    logic f_we, z_flag, done, m_z, m_done, m_fwe;
    logic [23:0] dir_out;
    logic [7:0] m_w, m_fw;
    logic [2:0][7:0] m_dir;
    int err_total = 0, n_checks = 0;
    always #2 clk = ~clk;
    nsd_decode i_dut (.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
        .instr(instr), .f_rdata(f_rdata), .dir_sel(dir_sel), .dir_we(dir_we),
        .dir_idx(dir_idx), .dir_wdata(dir_wdata), .dir_rdata(dir_rdata),
        .f_addr(f_addr), .f_wdata(f_wdata), .f_we(f_we), .w_out(w_out),
        .z_flag(z_flag), .dir_out(dir_out), .done(done));
    task summarize;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // reference model, one step per edge
    // ----------------------------------------
    // frozen cycles hold every registered output, pulses included
    always @(posedge clk) begin
        if (rst) begin
            m_w = 0;
            m_z = 0;
            m_dir = {3{8'hFF}};
            m_done = 0;
            m_fwe = 0;
        end else if (ce) begin
            m_done = 0;
            m_fwe = 0;
            if (instr_valid && instr[13:8] == 6'h3A) begin
                m_w = m_w ^ instr[7:0];
                m_z = (m_w == 0);
                m_done = 1;
            end else if (instr_valid && instr[13:8] == 6'h0E) begin
                m_done = 1;
                m_fw = {f_rdata[3:0], f_rdata[7:4]};
                if (instr[7]) m_fwe = 1;
                else m_w = m_fw;
            end else if (instr_valid && instr[13:3] == 11'h00C
                    && instr[2:0] >= 3'h5) begin
                m_dir[instr[2:0] - 3'h5] = m_w;
                m_done = 1;
            end
            // a recognised instruction drops a file write in its cycle
            if (!m_done && dir_sel && dir_we && dir_idx != 2'h3)
                m_dir[dir_idx] = dir_wdata;
        end
    end
    // ----------------------------------------
    // random stimulus, registered checks before each drive, read and address checks after it
    // ----------------------------------------
    initial begin
        void'($urandom(32'h70cb));
        repeat (20) @(negedge clk);
        rst = 0;
        for (int i = 0; i < 2000; i++) begin
            @(negedge clk);
            `CHK("w", m_w, w_out)
            `CHK("z", m_z, z_flag)
            `CHK("dir", m_dir, dir_out)
            `CHK("done", m_done, done)
            `CHK("fwe", m_fwe, f_we)
            if (m_fwe) `CHK("fdat", m_fw, f_wdata)
            // mid-run reset stands over one full rising edge
            rst = (i == 1000);
            ce = ($urandom % 8) != 0;
            case ($urandom % 5)
                0: instr = {6'h3A, ($urandom % 2) ? m_w : 8'($urandom)};
                1: instr = {6'h0E, 8'($urandom)};
                2: instr = {11'h00C, 3'($urandom)};
                default: instr = 14'($urandom);
            endcase
            instr_valid = ($urandom % 8) != 0;
            {dir_sel, dir_we, dir_idx} = 4'($urandom);
            dir_wdata = 8'($urandom); f_rdata = 8'($urandom);
            #1;
            `CHK("rd", (dir_idx == 3) ? 8'h00 : m_dir[dir_idx], dir_rdata)
            `CHK("addr", instr[6:0], f_addr)
        end
        summarize;
    end
    initial begin #20000; err_total++; summarize; end
endmodule
